// ===== rtl/sysctl_pkg.sv
// Shared constants for the system reset and test control block
package sysctl_pkg;

  localparam int unsigned RELEASE_HOLD_CYCLES = 16383;
  localparam int unsigned RELEASE_CNT_W       = 14;
  localparam int unsigned GPIO_W              = 8;
  localparam int unsigned TEST_SEL_W          = 3;
  localparam int unsigned PIN_SYNC_W          = 1 + TEST_SEL_W + GPIO_W;
  localparam int unsigned RST_SYNC_W          = 2;

  localparam logic [TEST_SEL_W-1:0] TEST_FUNCTIONAL = 3'h0;
  localparam logic [TEST_SEL_W-1:0] TEST_HIGH_Z     = 3'h3;
  localparam logic [GPIO_W-1:0]     GPIO_RESET      = 8'h00;
  localparam logic [GPIO_W-1:0]     GPIO_DIR_RESET  = 8'h00;

  typedef enum logic [2:0]
  {
    SEQ_HOLD  = 3'h1,
    SEQ_COUNT = 3'h2,
    SEQ_RUN   = 3'h4
  } seq_state_t;

endpackage : sysctl_pkg

// ===== rtl/pin_sync_if.sv
// Carrier between the pin filter and its user
`timescale 1ns/1ps
interface pin_sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport filter (input raw, output stable);
  modport user   (output raw, input stable);
endinterface : pin_sync_if

// ===== rtl/pin_filter.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_filter
  import sysctl_pkg::*;
#(
  parameter int unsigned W = 1
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  pin_sync_if.filter       pins
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] stable_r;
  logic [W-1:0] stable_nxt;

  // A bit moves only where the second and third stages agree
  always_comb
  begin
    stable_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & stable_r);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r     <= '0;
      s2_r     <= '0;
      s3_r     <= '0;
      stable_r <= '0;
    end
    else
    begin
      s1_r     <= pins.raw;
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      stable_r <= stable_nxt;
    end
  end

  assign pins.stable = stable_r;

endmodule : pin_filter

// ===== rtl/system_reset_and_test_control.sv
// Reset release sequencer, test select decode, freeze gate and GPIO register
//
// Overview of operation
// - After reset input rises, hold core reset for 16386 system clocks, 16383 of them counted.
// - Reset input is active low, asynchronous, forcing all registers to defaults.
// - Core logic and release counter run on the system clock.
// - Freeze-permit low blocks any software debug-freeze request.
// - Test select 000 is functional, 011 puts outputs high impedance.
// - Eight bidirectional GPIO pins connect to an internal register.
`timescale 1ns/1ps
module system_reset_and_test_control
  import sysctl_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = RELEASE_HOLD_CYCLES
)
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  freeze_permit,
  input  wire logic                  freeze_cmd,
  input  wire logic [TEST_SEL_W-1:0] test_select,
  input  wire logic                  gpio_wr_en,
  input  wire logic [GPIO_W-1:0]     gpio_wr_data,
  input  wire logic                  gpio_dir_wr_en,
  input  wire logic [GPIO_W-1:0]     gpio_dir_wr_data,
  input  wire logic [GPIO_W-1:0]     gpio_pin_level,
  output logic      [GPIO_W-1:0]     gpio_drive,
  output logic      [GPIO_W-1:0]     gpio_drive_en_n,
  output logic      [GPIO_W-1:0]     gpio_rd_data,
  output logic                       core_rst_n,
  output logic                       debug_freeze,
  output logic                       functional_operation,
  output logic                       outputs_high_impedance,
  output logic                       test_reserved
);

  pin_sync_if #(.W(PIN_SYNC_W)) pins ();

  logic [RST_SYNC_W-1:0]    rst_sync_r;
  logic [RST_SYNC_W-1:0]    rst_sync_nxt;
  seq_state_t               state_r;
  seq_state_t               state_nxt;
  logic [RELEASE_CNT_W-1:0] cnt_r;
  logic [RELEASE_CNT_W-1:0] cnt_nxt;
  logic                     core_rst_n_nxt;
  logic                     permit_s;
  logic [TEST_SEL_W-1:0]    test_s;
  logic [GPIO_W-1:0]        gpio_s;
  logic [GPIO_W-1:0]        gpio_r;
  logic [GPIO_W-1:0]        gpio_nxt;
  logic [GPIO_W-1:0]        gpio_dir_r;
  logic [GPIO_W-1:0]        gpio_dir_nxt;
  logic [GPIO_W-1:0]        gpio_rd_nxt;
  logic [GPIO_W-1:0]        gpio_drive_en_n_nxt;
  logic                     freeze_nxt;
  logic                     func_nxt;
  logic                     hiz_nxt;
  logic                     resv_nxt;

  assign pins.raw = {freeze_permit, test_select, gpio_pin_level};
  assign permit_s = pins.stable[PIN_SYNC_W-1];
  assign test_s   = pins.stable[GPIO_W +: TEST_SEL_W];
  assign gpio_s   = pins.stable[GPIO_W-1:0];

  pin_filter #(.W(PIN_SYNC_W)) u_pin_filter
  (
    .clock (clock),
    .rst_n (rst_n),
    .pins  (pins.filter)
  );

  // Reset assertion is immediate; release is retimed through two stages
  always_comb
  begin
    rst_sync_nxt = {rst_sync_r[0], 1'b1};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_r <= '0;
    else
      rst_sync_r <= rst_sync_nxt;
  end

  // Release sequencer: counts only once the synchronised release is seen
  always_comb
  begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    core_rst_n_nxt = 1'b0;
    case (state_r)
      SEQ_HOLD:
      begin
        cnt_nxt = '0;
        if (rst_sync_r[RST_SYNC_W-1])
          state_nxt = SEQ_COUNT;
      end
      SEQ_COUNT:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == RELEASE_CNT_W'(HOLD_CYCLES - 1))
        begin
          state_nxt      = SEQ_RUN;
          core_rst_n_nxt = 1'b1;
        end
      end
      SEQ_RUN:
      begin
        core_rst_n_nxt = 1'b1;
      end
      default:
      begin
        state_nxt = SEQ_HOLD;
        cnt_nxt   = '0;
      end
    endcase
  end

  // Core logic, including the counter, runs on the system clock
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r    <= SEQ_HOLD;
      cnt_r      <= '0;
      core_rst_n <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      core_rst_n <= core_rst_n_nxt;
    end
  end

  // Freeze gate, test decode and GPIO register
  always_comb
  begin
    // Permit overrides everything, and no freeze while the core is held
    freeze_nxt = freeze_cmd & permit_s & core_rst_n;
    func_nxt   = (test_s == TEST_FUNCTIONAL);
    hiz_nxt    = (test_s == TEST_HIGH_Z);
    resv_nxt   = !func_nxt && !hiz_nxt;
    gpio_nxt     = gpio_wr_en ? gpio_wr_data : gpio_r;
    gpio_dir_nxt = gpio_dir_wr_en ? gpio_dir_wr_data : gpio_dir_r;
    gpio_rd_nxt  = gpio_s;
    // High-impedance test mode releases every pin
    gpio_drive_en_n_nxt = hiz_nxt ? {GPIO_W{1'b1}} : ~gpio_dir_nxt;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      debug_freeze           <= 1'b0;
      functional_operation   <= 1'b0;
      outputs_high_impedance <= 1'b0;
      test_reserved          <= 1'b0;
      gpio_r                 <= GPIO_RESET;
      gpio_dir_r             <= GPIO_DIR_RESET;
      gpio_rd_data           <= '0;
      gpio_drive_en_n        <= '1;
    end
    else
    begin
      debug_freeze           <= freeze_nxt;
      functional_operation   <= func_nxt;
      outputs_high_impedance <= hiz_nxt;
      test_reserved          <= resv_nxt;
      gpio_r                 <= gpio_nxt;
      gpio_dir_r             <= gpio_dir_nxt;
      gpio_rd_data           <= gpio_rd_nxt;
      gpio_drive_en_n        <= gpio_drive_en_n_nxt;
    end
  end

  assign gpio_drive = gpio_r;

  core_release_a : assert property (@(posedge clock) disable iff (!rst_n)
    $rose(core_rst_n) |-> $past(state_r) == SEQ_COUNT && $past(cnt_r) == RELEASE_CNT_W'(HOLD_CYCLES - 1))
    else $error("core reset released before hold count");

  reset_defaults_a : assert property (@(posedge clock)
    !rst_n |-> !core_rst_n && !debug_freeze && gpio_drive == GPIO_RESET)
    else $error("registers not at defaults in reset");

  count_step_a : assert property (@(posedge clock) disable iff (!rst_n)
    state_r == SEQ_COUNT && $past(state_r) == SEQ_COUNT |-> cnt_r == $past(cnt_r) + 1'b1)
    else $error("release counter skipped a clock");

  freeze_gate_a : assert property (@(posedge clock) disable iff (!rst_n)
    debug_freeze |-> $past(permit_s) && $past(freeze_cmd))
    else $error("freeze asserted without permit");

  freeze_block_a : assert property (@(posedge clock) disable iff (!rst_n)
    !permit_s |=> !debug_freeze)
    else $error("freeze passed while permit low");

  test_decode_a : assert property (@(posedge clock) disable iff (!rst_n)
    test_s == TEST_HIGH_Z |=> outputs_high_impedance && !functional_operation && gpio_drive_en_n == '1)
    else $error("high impedance mode not applied");

  reserved_code_a : assert property (@(posedge clock) disable iff (!rst_n)
    test_s != TEST_FUNCTIONAL && test_s != TEST_HIGH_Z |=> test_reserved && !functional_operation)
    else $error("reserved test code not flagged");

  gpio_store_a : assert property (@(posedge clock) disable iff (!rst_n)
    gpio_wr_en ##1 !gpio_wr_en |-> gpio_drive == $past(gpio_wr_data))
    else $error("gpio register lost a write");

  gpio_sample_a : assert property (@(posedge clock) disable iff (!rst_n)
    gpio_rd_data == $past(gpio_s))
    else $error("gpio read data not the filtered pin level");

  release_sync_a : assert property (@(posedge clock) disable iff (!rst_n)
    state_r == SEQ_HOLD && !rst_sync_r[RST_SYNC_W-1] |=> state_r == SEQ_HOLD)
    else $error("count started before release synchronised");

  hold_length_a : assert property (@(posedge clock) disable iff (!rst_n)
    $rose(state_r == SEQ_COUNT) |-> !core_rst_n [*8])
    else $error("core reset dropped early in count");

endmodule : system_reset_and_test_control

// ===== tb/gpio_pad_model.sv
// Board pad model resolving each GPIO wire from device and board drivers
`timescale 1ns/1ps
module gpio_pad_model
  import sysctl_pkg::*;
(
  input  wire logic [GPIO_W-1:0] drive,
  input  wire logic [GPIO_W-1:0] drive_en_n,
  input  wire logic [GPIO_W-1:0] ext_level,
  output logic      [GPIO_W-1:0] pin_level
);
  // Device wins where it drives; the board level shows elsewhere
  assign pin_level = (drive & ~drive_en_n) | (ext_level & drive_en_n);
endmodule : gpio_pad_model

// ===== tb/system_reset_and_test_control_tb.sv
// Self-checking bench for reset release, test decode, freeze gate and GPIO
`timescale 1ns/1ps
module system_reset_and_test_control_tb;
  import sysctl_pkg::*;
  localparam int HOLD = 20;
  logic                  clock            = 1'b0;
  logic                  rst_n;
  logic                  freeze_permit    = 1'b0;
  logic                  freeze_cmd       = 1'b0;
  logic [TEST_SEL_W-1:0] test_select      = TEST_FUNCTIONAL;
  logic                  gpio_wr_en       = 1'b0;
  logic                  gpio_dir_wr_en   = 1'b0;
  logic [GPIO_W-1:0]     gpio_wr_data     = 8'h00;
  logic [GPIO_W-1:0]     gpio_dir_wr_data = 8'h00;
  logic [GPIO_W-1:0]     ext_level        = 8'h00;
  logic [GPIO_W-1:0]     pin_level;
  logic [GPIO_W-1:0]     gpio_drive;
  logic [GPIO_W-1:0]     gpio_drive_en_n;
  logic [GPIO_W-1:0]     gpio_rd_data;
  logic                  core_rst_n;
  logic                  debug_freeze;
  logic                  functional_operation;
  logic                  outputs_high_impedance;
  logic                  test_reserved;
  logic [15:0]           lfsr_state       = 16'hd3da;
  logic [GPIO_W-1:0]     dir;
  logic [GPIO_W-1:0]     exp_flags;
  int                    err_count        = 0;
  int                    cmp_count        = 0;

  always #20 clock = ~clock;

  system_reset_and_test_control #(.HOLD_CYCLES(HOLD)) u_dut (
    .clock(clock), .rst_n(rst_n), .freeze_permit(freeze_permit), .freeze_cmd(freeze_cmd),
    .test_select(test_select), .gpio_wr_en(gpio_wr_en), .gpio_wr_data(gpio_wr_data),
    .gpio_dir_wr_en(gpio_dir_wr_en), .gpio_dir_wr_data(gpio_dir_wr_data),
    .gpio_pin_level(pin_level), .gpio_drive(gpio_drive), .gpio_drive_en_n(gpio_drive_en_n),
    .gpio_rd_data(gpio_rd_data), .core_rst_n(core_rst_n), .debug_freeze(debug_freeze),
    .functional_operation(functional_operation), .outputs_high_impedance(outputs_high_impedance),
    .test_reserved(test_reserved));

  gpio_pad_model u_pad (.drive(gpio_drive), .drive_en_n(gpio_drive_en_n), .ext_level(ext_level),
    .pin_level(pin_level));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  // Both enables move together so no signal is set twice in one step
  task automatic wr(input logic en, input logic [7:0] dd, input logic [7:0] d);
    gpio_dir_wr_en   = en;
    gpio_wr_en       = en;
    gpio_dir_wr_data = dd;
    gpio_wr_data     = d;
    tick(1);
  endtask : wr

  // Metastable release edge allows one cycle either way
  task automatic release_check;
    int n;
    n = 0;
    rst_n = 1'b1;
    while (core_rst_n !== 1'b1 && n < HOLD + 10)
    begin
      tick(1);
      n++;
    end
    chk(8'(n >= HOLD + 2 && n <= HOLD + 4), 8'h01);
    if (n >= HOLD + 10)
      stop_test();
  endtask : release_check

  initial
  begin
    // A real falling edge, so the asynchronous reset acts before the first clock
    #1;
    rst_n = 1'b0;
    tick(20);
    chk({5'h00, core_rst_n, debug_freeze, functional_operation}, 8'h00);
    chk(gpio_drive_en_n, GPIO_DIR_RESET ^ 8'hff);
    release_check();
    repeat (4)
    begin
      lfsr_state = lfsr_next(lfsr_state);
      dir = lfsr_state[15:8] ^ lfsr_state[7:0];
      ext_level = ~lfsr_state[15:8];
      wr(1'b1, dir, lfsr_state[7:0]);
      wr(1'b0, 8'h00, 8'h00);
      tick(6);
      chk(gpio_drive, lfsr_state[7:0]);
      chk(gpio_drive_en_n, ~dir);
      chk(gpio_rd_data, (lfsr_state[7:0] & dir) | (ext_level & ~dir));
    end
    for (int c = 0; c < 8; c++)
    begin
      test_select = 3'(c);
      tick(6);
      exp_flags = (c == 0) ? 8'h04 : (c == 3) ? 8'h02 : 8'h01;
      chk({5'h00, functional_operation, outputs_high_impedance, test_reserved}, exp_flags);
      chk(gpio_drive_en_n, (c == 3) ? 8'hff : ~dir);
    end
    freeze_permit = 1'b1;
    tick(6);
    freeze_cmd = 1'b1;
    tick(1);
    chk(8'(debug_freeze), 8'h01);
    freeze_permit = 1'b0;
    tick(6);
    chk(8'(debug_freeze), 8'h00);
    rst_n = 1'b0;
    #1;
    chk(8'(core_rst_n), 8'h00);
    chk(gpio_drive, GPIO_RESET);
    tick(2);
    release_check();
    stop_test();
  end
endmodule : system_reset_and_test_control_tb
